// [design/cbt_pkg.sv]
// Summary of operation
// - propagation length is field 10:8 plus one
// - jump width is field 7:6 plus one
// - quantum lasts two times (prescaler+1) clocks
// - auto phase 2 when user select clear
// - timing writes only in configuration mode
// - filter enable bits 31/23/15/7
// - two-bit mask select picks mask 0..3
// - five-bit field picks receive fifo 0..31
// - one byte per filter, same layout
// - picks writable only while filter disabled
package cbt_pkg;
   // register word offsets (byte addresses)
   localparam logic [7:0]  MODCTL_OFF   = 8'h00;
   localparam logic [7:0]  TIMING_OFF   = 8'h04;
   localparam logic [7:0]  FILTER_OFF   = 8'h08;
   localparam logic [7:0]  STATUS_OFF   = 8'h0c;
   // module control fields
   localparam int          OPMODE_LSB   = 21;
   localparam logic [2:0]  CONFIG_MODE  = 3'h4;
   localparam logic [31:0] MODCTL_RST   = 32'h0080_0000;
   localparam logic [31:0] MODCTL_MASK  = 32'h00e0_0000;
   // bit timing fields
   localparam int          PRESC_LSB    = 0;
   localparam int          SJW_LSB      = 6;
   localparam int          PROP_LSB     = 8;
   localparam int          PH1_LSB      = 11;
   localparam int          SAMPLE3_BIT  = 14;
   localparam int          PH2SEL_BIT   = 15;
   localparam int          PH2_LSB      = 16;
   localparam logic [31:0] TIMING_RST   = 32'h0000_0000;
   localparam logic [31:0] TIMING_MASK  = 32'h0007_ffff;
   // filter byte layout, filters 4..7 in bytes 0..3
   localparam int          FEN_BIT      = 7;
   localparam int          MSEL_LSB     = 5;
   localparam int          FSEL_LSB     = 0;
   localparam logic [7:0]  FILTER_RST   = 8'h00;
   // status fields
   localparam int          QPB_LSB      = 0;
   localparam int          ERR_LSB      = 8;
   // legality limits
   localparam logic [4:0]  MIN_QUANTA   = 5'h07;
   localparam logic [5:0]  SAMPLE3_MINP = 6'h02;
   // bus answers
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// [design/cbt_quantum_gen.sv]
`timescale 1ns/1ps
// time quantum divider: one-cycle tick every 2*(presc+1) clocks
module cbt_quantum_gen (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [5:0] presc,
   output logic            tq_tick
);
   logic [6:0] cnt_r;
   logic [6:0] last_w;

   // terminal count is 2*(presc+1)-1, i.e. presc with a one appended
   assign last_w = {presc, 1'b1};

   // a prescaler shrunk below the count restarts at once, no wraparound
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r   <= 7'h00;
         tq_tick <= 1'b0;
      end else if (cnt_r >= last_w) begin
         cnt_r   <= 7'h00;
         tq_tick <= 1'b1;
      end else begin
         cnt_r   <= cnt_r + 7'h01;
         tq_tick <= 1'b0;
      end
   end
endmodule

// [design/cbt_top.sv]
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// bit timing and filter control, AXI4-Lite register slave
module cbt_top (
   input  wire logic        clk,
   input  wire logic        rst,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // timing results toward the bit engine
   output logic             time_quantum_tick,
   output logic [3:0]       prop_segment_len,
   output logic [2:0]       resync_jump_width,
   output logic [3:0]       phase1_len,
   output logic [3:0]       phase2_len,
   output logic [4:0]       quanta_per_bit,
   output logic             three_sample,
   output logic             timing_fault,
   output logic [2:0]       requested_op_mode,
   // filter controls, filter 4 in the low entry
   output logic [3:0]       filter_on,
   output logic [7:0]       filter_mask_pick,
   output logic [19:0]      filter_fifo_pick
);
   // write channel state
   logic        aw_hold_r;
   logic [7:0]  awaddr_r;
   logic        w_hold_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        do_write;
   // read channel state
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   // registers
   logic [31:0] modctl_r;
   logic [31:0] timing_r;
   logic [7:0]  filt_r [4];
   logic [31:0] filt_word;
   logic [31:0] timing_view;
   logic [31:0] status_view;
   // decoded timing
   logic [2:0]  ph2_field;
   logic [3:0]  prop_q, ph1_q, ph2_q;
   logic [2:0]  sjw_q;
   logic [4:0]  qpb_nxt;
   logic [3:0]  err_nxt;
   logic [3:0]  err_r;
   logic        config_mode;

   // true when the word address names an implemented register
   function automatic logic addr_known(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      if (a[7:2] == cbt_pkg::MODCTL_OFF[7:2])
         hit = 1'b1;
      else if (a[7:2] == cbt_pkg::TIMING_OFF[7:2])
         hit = 1'b1;
      else if (a[7:2] == cbt_pkg::FILTER_OFF[7:2])
         hit = 1'b1;
      else if (a[7:2] == cbt_pkg::STATUS_OFF[7:2])
         hit = 1'b1;
      return hit;
   endfunction

   // merge written bytes into the old value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i])
            res[8*i +: 8] = nw[8*i +: 8];
      end
      return res;
   endfunction

   // handshake outputs; address and data may arrive in either order
   assign s_axi_awready = !aw_hold_r && !bvalid_r;
   assign s_axi_wready  = !w_hold_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign do_write      = aw_hold_r && w_hold_r && !bvalid_r;

   // capture write address and data, answer once both are held
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_hold_r <= 1'b0;
         awaddr_r  <= 8'h00;
         w_hold_r  <= 1'b0;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= cbt_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= addr_known(awaddr_r) ? cbt_pkg::RESP_OKAY
                                              : cbt_pkg::RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // module control: only the mode field is implemented
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         modctl_r <= cbt_pkg::MODCTL_RST;
      else if (do_write && awaddr_r[7:2] == cbt_pkg::MODCTL_OFF[7:2])
         modctl_r <= merge(modctl_r, wdata_r, wstrb_r)
                     & cbt_pkg::MODCTL_MASK;
   end

   assign requested_op_mode = modctl_r[cbt_pkg::OPMODE_LSB +: 3];
   assign config_mode = (requested_op_mode == cbt_pkg::CONFIG_MODE);

   // timing register is frozen outside configuration mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         timing_r <= cbt_pkg::TIMING_RST;
      else if (do_write && config_mode
               && awaddr_r[7:2] == cbt_pkg::TIMING_OFF[7:2])
         timing_r <= merge(timing_r, wdata_r, wstrb_r)
                     & cbt_pkg::TIMING_MASK;
   end

   // phase 2 follows phase 1 unless software owns it
   assign ph2_field = timing_r[cbt_pkg::PH2SEL_BIT]
                    ? timing_r[cbt_pkg::PH2_LSB +: 3]
                    : timing_r[cbt_pkg::PH1_LSB +: 3];

   // field value plus one gives the length in quanta
   always_comb begin
      prop_q = {1'b0, timing_r[cbt_pkg::PROP_LSB +: 3]} + 4'h1;
      sjw_q  = {1'b0, timing_r[cbt_pkg::SJW_LSB +: 2]} + 3'h1;
      ph1_q  = {1'b0, timing_r[cbt_pkg::PH1_LSB +: 3]} + 4'h1;
      ph2_q  = {1'b0, ph2_field} + 4'h1;
      qpb_nxt = 5'h01 + {1'b0, prop_q} + {1'b0, ph1_q}
              + {1'b0, ph2_q};
      // software keeps these; the block only reports breaches
      err_nxt[0] = (ph2_q > ph1_q);
      err_nxt[1] = timing_r[cbt_pkg::SAMPLE3_BIT]
                   && (timing_r[cbt_pkg::PRESC_LSB +: 6]
                       < cbt_pkg::SAMPLE3_MINP);
      err_nxt[2] = ({1'b0, sjw_q} > ph2_q);
      err_nxt[3] = (qpb_nxt <= cbt_pkg::MIN_QUANTA);
   end

   // registered timing outputs, one cycle behind the register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prop_segment_len  <= 4'h1;
         resync_jump_width <= 3'h1;
         phase1_len        <= 4'h1;
         phase2_len        <= 4'h1;
         quanta_per_bit    <= 5'h04;
         three_sample      <= 1'b0;
         err_r             <= 4'h0;
         timing_fault      <= 1'b0;
      end else begin
         prop_segment_len  <= prop_q;
         resync_jump_width <= sjw_q;
         phase1_len        <= ph1_q;
         phase2_len        <= ph2_q;
         quanta_per_bit    <= qpb_nxt;
         three_sample      <= timing_r[cbt_pkg::SAMPLE3_BIT];
         err_r             <= err_nxt;
         timing_fault      <= |err_nxt;
      end
   end

   // quantum tick generator
   cbt_quantum_gen u_tq (
      .clk     (clk),
      .rst     (rst),
      .presc   (timing_r[cbt_pkg::PRESC_LSB +: 6]),
      .tq_tick (time_quantum_tick)
   );

   // one byte per filter; picks locked while the filter is on
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_filt
         logic wr_k;
         assign wr_k = do_write && wstrb_r[k]
                    && awaddr_r[7:2] == cbt_pkg::FILTER_OFF[7:2];
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               filt_r[k] <= cbt_pkg::FILTER_RST;
            end else if (wr_k) begin
               filt_r[k][cbt_pkg::FEN_BIT] <=
                  wdata_r[8*k + cbt_pkg::FEN_BIT];
               if (!filt_r[k][cbt_pkg::FEN_BIT]) begin
                  filt_r[k][6:0] <= wdata_r[8*k +: 7];
               end
            end
         end
         assign filt_word[8*k +: 8] = filt_r[k];
         assign filter_on[k] = filt_r[k][cbt_pkg::FEN_BIT];
         assign filter_mask_pick[2*k +: 2] =
                filt_r[k][cbt_pkg::MSEL_LSB +: 2];
         assign filter_fifo_pick[5*k +: 5] =
                filt_r[k][cbt_pkg::FSEL_LSB +: 5];

         a_pick_lock: assert property (
            @(posedge clk) disable iff (rst)
            wr_k && filt_r[k][cbt_pkg::FEN_BIT] |=>
               $stable(filt_r[k][6:0]))
            else $error("filter pick changed while enabled");

         a_pick_take: assert property (
            @(posedge clk) disable iff (rst)
            wr_k && !filt_r[k][cbt_pkg::FEN_BIT] |=>
               filter_mask_pick[2*k +: 2] == $past(wdata_r[8*k+5 +: 2])
               && filter_fifo_pick[5*k +: 5] == $past(wdata_r[8*k +: 5]))
            else $error("filter picks not taken from write");

         a_enable_take: assert property (
            @(posedge clk) disable iff (rst)
            wr_k |=> filter_on[k] == $past(wdata_r[8*k+7]))
            else $error("filter enable not taken from write");
      end
   endgenerate

   // read views: timing shows effective phase 2
   always_comb begin
      timing_view = timing_r;
      timing_view[cbt_pkg::PH2_LSB +: 3] = ph2_field;
      status_view = 32'h0000_0000;
      status_view[cbt_pkg::QPB_LSB +: 5] = quanta_per_bit;
      status_view[cbt_pkg::ERR_LSB +: 4] = err_r;
   end

   // read channel: one outstanding read, data held until taken
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= cbt_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rresp_r  <= addr_known(s_axi_araddr) ? cbt_pkg::RESP_OKAY
                                              : cbt_pkg::RESP_SLVERR;
         if (s_axi_araddr[7:2] == cbt_pkg::MODCTL_OFF[7:2])
            rdata_r <= modctl_r;
         else if (s_axi_araddr[7:2] == cbt_pkg::TIMING_OFF[7:2])
            rdata_r <= timing_view;
         else if (s_axi_araddr[7:2] == cbt_pkg::FILTER_OFF[7:2])
            rdata_r <= filt_word;
         else if (s_axi_araddr[7:2] == cbt_pkg::STATUS_OFF[7:2])
            rdata_r <= status_view;
         else
            rdata_r <= 32'h0000_0000;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // helper: cycles since the last quantum tick and prescaler stability
   logic [7:0] tq_gap_r;
   logic       presc_steady_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tq_gap_r       <= 8'h00;
         presc_steady_r <= 1'b0;
      end else if (time_quantum_tick) begin
         tq_gap_r       <= 8'h01;
         presc_steady_r <= 1'b1;
      end else begin
         tq_gap_r <= (tq_gap_r == 8'hff) ? tq_gap_r : tq_gap_r + 8'h01;
         if ($changed(timing_r[5:0]))
            presc_steady_r <= 1'b0;
      end
   end

   a_tq_period: assert property (
      @(posedge clk) disable iff (rst)
      time_quantum_tick && presc_steady_r && $stable(timing_r[5:0]) |->
         tq_gap_r == {1'b0, timing_r[5:0], 1'b0} + 8'h02)
      else $error("quantum period is not two times prescaler plus one");

   sequence s_timing_write;
      do_write && awaddr_r[7:2] == cbt_pkg::TIMING_OFF[7:2]
      && wstrb_r == 4'hf;
   endsequence

   a_timing_locked: assert property (
      @(posedge clk) disable iff (rst)
      do_write && awaddr_r[7:2] == cbt_pkg::TIMING_OFF[7:2]
      && !config_mode |=> $stable(timing_r))
      else $error("timing written outside configuration mode");

   a_timing_taken: assert property (
      @(posedge clk) disable iff (rst)
      s_timing_write and config_mode |=>
         timing_r[10:0] == $past(wdata_r[10:0]))
      else $error("timing write in configuration mode lost");

   a_prop_len: assert property (
      @(posedge clk) disable iff (rst)
      s_timing_write and config_mode |=> ##1
         prop_segment_len == {1'b0, $past(wdata_r[10:8], 2)} + 4'h1)
      else $error("propagation length not field plus one");

   a_jump_width: assert property (
      @(posedge clk) disable iff (rst)
      s_timing_write and config_mode |=> ##1
         resync_jump_width == {1'b0, $past(wdata_r[7:6], 2)} + 3'h1)
      else $error("jump width not field plus one");

   a_phase2_auto: assert property (
      @(posedge clk) disable iff (rst)
      !timing_r[cbt_pkg::PH2SEL_BIT] |=> phase2_len == phase1_len)
      else $error("automatic phase 2 differs from phase 1");

   a_bit_sum: assert property (
      @(posedge clk) disable iff (rst)
      quanta_per_bit == 5'h01 + {1'b0, prop_segment_len}
                      + {1'b0, phase1_len} + {1'b0, phase2_len})
      else $error("quanta per bit is not the segment sum");
endmodule

// [test/cbt_engine_model.sv]
`timescale 1ns/1ps
// bit engine stand-in: watches the quantum tick like the sampler would
module cbt_engine_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       tick,
   output logic [7:0]      gap
);
   logic [7:0] cnt_r;

   // spacing of the last two ticks; the first gap after a prescaler
   // change may be short, so readers wait a few periods
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 8'h01;
         gap   <= 8'h00;
      end else if (tick) begin
         gap   <= cnt_r;
         cnt_r <= 8'h01;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
// register-level regression of the bit timing and filter controls
module testbench;
   logic        clk, rst;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        time_quantum_tick, three_sample, timing_fault;
   logic [3:0]  prop_segment_len, phase1_len, phase2_len, filter_on;
   logic [2:0]  resync_jump_width, requested_op_mode;
   logic [4:0]  quanta_per_bit;
   logic [7:0]  filter_mask_pick, gap;
   logic [19:0] filter_fifo_pick;
   logic [5:0]  pre [4] = '{6'h00, 6'h01, 6'h05, 6'h3f};
   int          mismatches, checked, cycles, exp_prop;

   cbt_top i_cbt_top (
      .clk               (clk),
      .rst               (rst),
      .s_axi_awaddr      (s_axi_awaddr),
      .s_axi_awvalid     (s_axi_awvalid),
      .s_axi_awready     (s_axi_awready),
      .s_axi_wdata       (s_axi_wdata),
      .s_axi_wstrb       (s_axi_wstrb),
      .s_axi_wvalid      (s_axi_wvalid),
      .s_axi_wready      (s_axi_wready),
      .s_axi_bresp       (s_axi_bresp),
      .s_axi_bvalid      (s_axi_bvalid),
      .s_axi_bready      (s_axi_bready),
      .s_axi_araddr      (s_axi_araddr),
      .s_axi_arvalid     (s_axi_arvalid),
      .s_axi_arready     (s_axi_arready),
      .s_axi_rdata       (s_axi_rdata),
      .s_axi_rresp       (s_axi_rresp),
      .s_axi_rvalid      (s_axi_rvalid),
      .s_axi_rready      (s_axi_rready),
      .time_quantum_tick (time_quantum_tick),
      .prop_segment_len  (prop_segment_len),
      .resync_jump_width (resync_jump_width),
      .phase1_len        (phase1_len),
      .phase2_len        (phase2_len),
      .quanta_per_bit    (quanta_per_bit),
      .three_sample      (three_sample),
      .timing_fault      (timing_fault),
      .requested_op_mode (requested_op_mode),
      .filter_on         (filter_on),
      .filter_mask_pick  (filter_mask_pick),
      .filter_fifo_pick  (filter_fifo_pick)
   );
   cbt_engine_model i_cbt_engine_model (.clk(clk), .rst(rst),
      .tick(time_quantum_tick), .gap(gap));

   always #4 clk = ~clk;

   // hang guard: the whole run needs well under two thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t: %s seen %h want %h", $time, what, seen, exp);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // reset state: configuration mode, minimum lengths, filters clear
      chk(requested_op_mode, cbt_pkg::CONFIG_MODE, "mode");
      rd(cbt_pkg::MODCTL_OFF);
      chk(rdat, cbt_pkg::MODCTL_RST, "modctl");
      rd(cbt_pkg::FILTER_OFF);
      chk(rdat, 32'h0, "filter reset");
      chk(prop_segment_len, 1, "prop");
      chk(resync_jump_width, 1, "sjw");
      chk(quanta_per_bit, 4, "qpb");
      // four quanta per bit is below the minimum, so the report is up
      chk(timing_fault, 1, "fault reset");
      rd(cbt_pkg::STATUS_OFF);
      chk(rdat, 32'h0000_0804, "status reset");
      $display("test reset done");
      // every propagation code with a cycling jump width, user phase 2
      for (int p = 0; p < 8; p++) begin
         wr(cbt_pkg::TIMING_OFF, {13'h0, 3'h7, 2'b10, 3'h7, p[2:0], p[1:0],
                                  6'h00});
         chk(prop_segment_len, p + 1, "prop");
         chk(resync_jump_width, (p % 4) + 1, "sjw");
         chk(quanta_per_bit, p + 18, "qpb");
         chk(phase2_len, 8, "phase2 user");
         chk(timing_fault, 0, "fault");
      end
      $display("test segments done");
      // three-sample only once the prescaler is two or more
      foreach (pre[i]) begin
         wr(cbt_pkg::TIMING_OFF, {13'h0, 3'h7, 1'b1, pre[i] >= 6'h02, 3'h7,
                                  5'h00, pre[i]});
         repeat (6 * (pre[i] + 1) + 4) @(posedge clk);
         chk(gap, 2 * (pre[i] + 1), "quantum");
         chk(three_sample, pre[i] >= 6'h02, "sample3");
      end
      $display("test quantum done");
      // automatic phase 2 follows phase 1 when the user select is clear
      wr(cbt_pkg::TIMING_OFF, {13'h0, 3'h1, 2'b00, 3'h5, 3'h2, 2'h0, 6'h0});
      chk(phase1_len, 6, "phase1");
      chk(phase2_len, 6, "phase2 auto");
      chk(quanta_per_bit, 16, "qpb");
      rd(cbt_pkg::TIMING_OFF);
      chk(rdat, {13'h0, 3'h5, 2'b00, 3'h5, 3'h2, 8'h0},
          "timing rd");
      $display("test auto phase done");
      // timing writes only land in configuration mode
      exp_prop = 3;
      for (int m = 0; m < 8; m++) begin
         wr(cbt_pkg::MODCTL_OFF, {8'h0, m[2:0], 21'h0});
         chk(requested_op_mode, m, "mode");
         wr(cbt_pkg::TIMING_OFF, {13'h0, 3'h5, 2'b00, 3'h5, m[2:0], 8'h0});
         chk(resp, cbt_pkg::RESP_OKAY, "bresp");
         if (m == 4)
            exp_prop = 5;
         chk(prop_segment_len, exp_prop, "gated prop");
      end
      wr(cbt_pkg::MODCTL_OFF, cbt_pkg::MODCTL_RST);
      $display("test mode gate done");
      // picks take while disabled, freeze while enabled
      wr(cbt_pkg::FILTER_OFF, 32'h7f50_2100);
      chk(filter_mask_pick, 8'b11_10_01_00, "msel");
      chk(filter_fifo_pick, {5'h1f, 5'h10, 5'h01, 5'h00},
          "fsel");
      wr(cbt_pkg::FILTER_OFF, 32'hff_d0_00_00);
      chk(filter_on, 4'b1100, "enables");
      wr(cbt_pkg::FILTER_OFF, 32'h80_80_21_21);
      rd(cbt_pkg::FILTER_OFF);
      chk(rdat, 32'hff_d0_21_21, "locked picks");
      chk(filter_fifo_pick, {5'h1f, 5'h10, 5'h01, 5'h01},
          "fsel");
      wr(cbt_pkg::FILTER_OFF, 32'h0);
      rd(cbt_pkg::FILTER_OFF);
      chk(rdat, 32'h7f_50_00_00, "disable only");
      chk(filter_on, 4'b0000, "enables");
      $display("test filters done");
      // unmapped word: error answer, no effect, reads zero
      wr(8'h10, 32'hffff_ffff);
      chk(resp, cbt_pkg::RESP_SLVERR, "unmapped wr");
      rd(8'h10);
      chk(resp, cbt_pkg::RESP_SLVERR, "unmapped rd");
      chk(rdat, 32'h0, "unmapped data");
      rd(cbt_pkg::FILTER_OFF);
      chk(rdat, 32'h7f_50_00_00, "filter kept");
      $display("test unmapped done");
      // one byte lane only: filter 5 alone takes the write
      s_axi_wstrb <= 4'h2;
      wr(cbt_pkg::FILTER_OFF, 32'hffff_ffff);
      rd(cbt_pkg::FILTER_OFF);
      chk(rdat, 32'h7f_50_ff_00, "lane write");
      chk(filter_on, 4'b0010, "lane enable");
      $display("test strobes done");
      report_and_stop();
   end
endmodule
